// >>> mem_channel_model.sv
// delay-line memory channel feeding the serial read line
module mem_channel_model (
    input  wire logic        clk,
    input  wire logic        word_select,
    input  wire logic [5:0]  pulse_source,
    input  wire logic [41:0] stored_word,
    output logic             memory_read_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // lsb first, one position per pulse
    // a closed output gate reads as zeros
    assign memory_read_line = word_select & stored_word[pulse_source];
endmodule

// >>> serial_add_order.sv
// execute phase of the bit-serial add order with an avalon register slave
//
// Our own choices: the Avalon-MM register port and the address map.
module serial_add_order (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [4:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [3:0]           byteenable,
    input  wire logic [31:0]          writedata,
    output logic      [31:0]          readdata,
    output logic                      waitrequest,
    input  wire logic                 memory_read_line,
    output logic                      word_select,
    output logic                      readout_select_strobe,
    output logic      [20:0]          function_line,
    output logic      [3:0]           word_slot_counter,
    output logic      [5:0]           pulse_source,
    output logic      [1:0]           step_counter,
    output logic      [1:0]           phase_counter,
    output logic                      settle_hold,
    output logic                      overflow_flop
);
    typedef struct packed {
        logic [5:0]                   pulse;
        logic [3:0]                   slot;
        serial_add_pkg::phase_t       phase;
        logic [1:0]                   step;
        logic                         hold;
        logic                         ws;
        logic [3:0]                   addr;
        logic [41:0]                  acc;
        logic [41:0]                  opd;
        logic                         mag_greater;
        logic                         sign_differs;
        logic                         mag_cmp;
        logic                         nonzero;
        logic                         carry;
        logic                         overflow;
        logic                         ack;
        logic [31:0]                  rdata;
    } state_t;
    state_t      cur;
    state_t      next_cur;
    logic [20:0] lines;
    logic        active;
    logic        t0;
    logic        swap_inputs;
    logic        complement_enable;
    logic [5:0]  cmp_pos;
    logic [5:0]  add_pos;
    logic        upper_bit;
    logic        lower_bit;
    logic        carry_in;
    logic        sum_bit;
    logic        carry_out;
    logic        cmp_now;
    logic        idle;
    function automatic logic [20:0] decode_lines(
        serial_add_pkg::phase_t ph,
        logic [1:0]             st
    );
        logic [20:0] v;
        v = '0;
        if (ph == serial_add_pkg::PH_GAMMA) begin
            unique case (st)
                2'h0: begin
                    v[serial_add_pkg::LN_READ]     = 1'b1;
                    v[serial_add_pkg::LN_STROBE]   = 1'b1;
                    v[serial_add_pkg::LN_OPD_IN]   = 1'b1;
                    v[serial_add_pkg::LN_READ_END] = 1'b1;
                end
                2'h1: begin
                    v[serial_add_pkg::LN_CMP]      = 1'b1;
                    v[serial_add_pkg::LN_CMP_AUX]  = 1'b1;
                end
                2'h2: begin
                    v[serial_add_pkg::LN_ADD_END]  = 1'b1;
                    v[serial_add_pkg::LN_HOLD_RES] = 1'b1;
                    v[serial_add_pkg::LN_ADD]      = 1'b1;
                end
                default: v = '0;
            endcase
        end
        return v;
    endfunction
    // position seen at a pulse under a given reference timing
    function automatic logic [5:0] pos_of(logic [5:0] t, logic [5:0] ofs);
        logic [6:0] s;
        s = {1'b0, t} + {1'b0, ofs};
        if (s >= {1'b0, serial_add_pkg::PULSES}) begin
            s = s - {1'b0, serial_add_pkg::PULSES};
        end
        return s[5:0];
    endfunction
    function automatic logic [31:0] merge_be(
        logic [31:0] old,
        logic [31:0] data,
        logic [3:0]  be
    );
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return v;
    endfunction
    always_comb begin
        next_cur    = cur;
        lines       = decode_lines(cur.phase, cur.step);
        t0          = (cur.pulse == serial_add_pkg::T_FIRST);
        idle        = (cur.phase != serial_add_pkg::PH_GAMMA);
        active      = !idle && !cur.hold;
        cmp_pos     = pos_of(cur.pulse, serial_add_pkg::CMP_OFS);
        add_pos     = pos_of(cur.pulse, serial_add_pkg::ADD_OFS);
        // complement from line 20 and sign-differs
        complement_enable = lines[serial_add_pkg::LN_ADD] && cur.sign_differs;
        swap_inputs = lines[serial_add_pkg::LN_HOLD_RES] && !cur.mag_greater;
        upper_bit   = swap_inputs ? cur.opd[add_pos] : cur.acc[add_pos];
        lower_bit   = swap_inputs ? cur.acc[add_pos] : cur.opd[add_pos];
        if (add_pos == serial_add_pkg::P_SIGN) begin
            lower_bit = 1'b0;
        end
        if (complement_enable && cur.pulse >= serial_add_pkg::T_CP_FIRST
                && cur.pulse <= serial_add_pkg::T_CP_LAST) begin
            lower_bit = !lower_bit;
        end
        // carry delayed one pulse, plus injected carry
        carry_in = cur.carry;
        if (complement_enable && cur.pulse == serial_add_pkg::T_CP_FIRST) begin
            carry_in = 1'b1;
        end
        sum_bit   = upper_bit ^ lower_bit ^ carry_in;
        carry_out = (upper_bit & lower_bit)
                    | (carry_in & (upper_bit ^ lower_bit));
        cmp_now   = cur.mag_cmp;
        if (cmp_pos <= serial_add_pkg::P_MAG_HI
                && cur.acc[cmp_pos] != cur.opd[cmp_pos]) begin
            cmp_now = cur.acc[cmp_pos];
        end
        // 42 pulse times per minor cycle
        next_cur.pulse = (cur.pulse == serial_add_pkg::T_LAST) ?
                         serial_add_pkg::T_FIRST : cur.pulse + 6'h01;
        // slot advances on t2, modulo ten
        if (cur.pulse == serial_add_pkg::T_SLOT_STEP) begin
            next_cur.slot = (cur.slot == serial_add_pkg::SLOT_LAST) ?
                            4'h0 : cur.slot + 4'h1;
        end
        // settle hold lasts until the next t0; overflow freezes it
        if (t0 && cur.hold && !idle && !cur.overflow) begin
            next_cur.hold = 1'b0;
        end
        // step 0: read the addressed word into the operand
        if (cur.step == 2'h0 && active) begin
            // slot match sets word select at t0
            if (t0 && !cur.ws && lines[serial_add_pkg::LN_READ]
                    && cur.slot == cur.addr) begin
                next_cur.ws = 1'b1;
            end
            // following t0 closes the read step
            if (t0 && cur.ws && lines[serial_add_pkg::LN_READ_END]) begin
                next_cur.step = 2'h1;
                next_cur.hold = 1'b1;
                next_cur.ws   = 1'b0;
            end
        end
        // operand input open during word select
        // position 0 arrives last, at the t0 that closes the read
        if (cur.ws && lines[serial_add_pkg::LN_OPD_IN]) begin
            next_cur.opd[cur.pulse] = memory_read_line;
        end
        // step 1: compare signs and magnitudes
        if (active && lines[serial_add_pkg::LN_CMP]) begin
            next_cur.mag_cmp = cmp_now;
            if (cur.pulse == serial_add_pkg::T_CLR_CMP) begin
                next_cur.mag_cmp = 1'b0;
                next_cur.nonzero = 1'b0;
            end
            // t2 clears both results, line 14 blocks it
            if (cur.pulse == serial_add_pkg::T_CLR_RES
                    && !lines[serial_add_pkg::LN_HOLD_RES]) begin
                next_cur.sign_differs = 1'b0;
                next_cur.mag_greater  = 1'b0;
            end
            if (cur.pulse == serial_add_pkg::T_MAG && cmp_now) begin
                next_cur.mag_greater = 1'b1;
            end
            // half adder on sign position at t35
            if (cur.pulse == serial_add_pkg::T_SIGN
                    && (cur.acc[serial_add_pkg::P_SIGN]
                        ^ cur.opd[serial_add_pkg::P_SIGN])) begin
                next_cur.sign_differs = 1'b1;
            end
            // end compare at next t0, no word select needed
            if (t0) begin
                next_cur.step = 2'h2;
                next_cur.hold = 1'b1;
            end
        end
        // step 2: serial add into the accumulator
        if (active && lines[serial_add_pkg::LN_ADD]) begin
            next_cur.carry = carry_out;
            if (add_pos >= serial_add_pkg::P_MAG_LO
                    && add_pos <= serial_add_pkg::P_MAG_HI) begin
                next_cur.acc[add_pos] = sum_bit;
                if (sum_bit) begin
                    next_cur.nonzero = 1'b1;
                end
            end
            if (add_pos == serial_add_pkg::P_MAG_HI) begin
                // carry past the magnitude never reaches the sign
                next_cur.carry = 1'b0;
                if (carry_out && !complement_enable) begin
                    next_cur.overflow = 1'b1;
                end
            end
            // zero magnitude always takes plus sign
            if (add_pos == serial_add_pkg::P_SIGN) begin
                next_cur.acc[add_pos] = sum_bit & cur.nonzero;
            end
            if (t0) begin
                next_cur.carry   = 1'b0;
                next_cur.nonzero = 1'b0;
            end
            // line 10 passes t0 as the ending pulse
            if (t0 && lines[serial_add_pkg::LN_ADD_END]) begin
                next_cur.hold  = 1'b1;
                next_cur.step  = 2'h0;
                next_cur.phase = serial_add_pkg::PH_ALPHA;
            end
        end
        // register slave: one wait cycle, then the answer
        next_cur.ack = (read || write) && !cur.ack;
        if (read && !cur.ack) begin
            unique case (address)
                serial_add_pkg::REG_CTRL:
                    next_cur.rdata = {24'h000000, cur.addr, 4'h0};
                serial_add_pkg::REG_STATUS:
                    next_cur.rdata = {13'h0000, cur.pulse, cur.slot,
                                      cur.overflow, cur.sign_differs,
                                      cur.mag_greater, cur.ws, cur.hold,
                                      cur.step, cur.phase};
                serial_add_pkg::REG_ACC_LO:
                    next_cur.rdata = cur.acc[31:0];
                serial_add_pkg::REG_ACC_HI:
                    next_cur.rdata = {22'h000000, cur.acc[41:32]};
                serial_add_pkg::REG_OPD_LO:
                    next_cur.rdata = cur.opd[31:0];
                serial_add_pkg::REG_OPD_HI:
                    next_cur.rdata = {22'h000000, cur.opd[41:32]};
                serial_add_pkg::REG_LINES:
                    next_cur.rdata = {11'h000, lines};
                default:
                    next_cur.rdata = 32'h00000000;
            endcase
        end
        if (write && cur.ack) begin
            // accumulator is only writable between orders
            if (address == serial_add_pkg::REG_ACC_LO && idle) begin
                next_cur.acc[31:0] = merge_be(cur.acc[31:0], writedata,
                                              byteenable);
            end
            if (address == serial_add_pkg::REG_ACC_HI && idle
                    && byteenable[0]) begin
                next_cur.acc[41:32] = writedata[serial_add_pkg::HI_W-1:0];
            end
            if (address == serial_add_pkg::REG_CTRL && byteenable[0]) begin
                if (writedata[serial_add_pkg::CTRL_START]
                        && (idle || cur.overflow)) begin
                    next_cur.phase    = serial_add_pkg::PH_GAMMA;
                    next_cur.step     = 2'h0;
                    next_cur.hold     = 1'b1;
                    next_cur.ws       = 1'b0;
                    next_cur.overflow = 1'b0;
                    next_cur.addr     =
                        writedata[serial_add_pkg::CTRL_SLOT_LO +: 4];
                end else if (writedata[serial_add_pkg::CTRL_ABORT]) begin
                    next_cur.phase    = serial_add_pkg::PH_ALPHA;
                    next_cur.step     = 2'h0;
                    next_cur.hold     = 1'b1;
                    next_cur.ws       = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur       <= '0;
            cur.phase <= serial_add_pkg::PH_ALPHA;
            cur.hold  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end
    assign readdata              = cur.rdata;
    assign waitrequest           = (read || write) && !cur.ack;
    assign word_select           = cur.ws;
    // read-out strobe from word select and line 3
    assign readout_select_strobe = cur.ws && lines[serial_add_pkg::LN_STROBE];
    assign function_line         = lines;
    assign word_slot_counter     = cur.slot;
    assign pulse_source          = cur.pulse;
    assign step_counter          = cur.step;
    assign phase_counter         = cur.phase;
    assign settle_hold           = cur.hold;
    assign overflow_flop         = cur.overflow;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    ws_set_a: assert property (
        active && cur.step == 2'h0 && t0 && !cur.ws
        && cur.slot == cur.addr |=> cur.ws && readout_select_strobe)
        else $error("word select not set on slot match");
    opd_load_a: assert property (
        cur.ws && lines[serial_add_pkg::LN_OPD_IN]
        |=> cur.opd[$past(cur.pulse)] == $past(memory_read_line))
        else $error("operand bit not loaded from memory");
    read_end_a: assert property (
        active && cur.step == 2'h0 && cur.ws && t0
        |=> cur.step == 2'h1 && cur.hold && !cur.ws)
        else $error("read step did not close");
    step1_lines_a: assert property (
        cur.phase == serial_add_pkg::PH_GAMMA && cur.step == 2'h1
        |-> function_line[13] && function_line[16] && !function_line[1]
            && !function_line[3] && !function_line[12] && !function_line[19])
        else $error("wrong lines in compare step");
    result_clr_a: assert property (
        active && cur.step == 2'h1 && cur.pulse == serial_add_pkg::T_CLR_RES
        |=> !cur.sign_differs && !cur.mag_greater)
        else $error("comparison results not cleared");
    sign_diff_a: assert property (
        active && cur.step == 2'h1 && cur.pulse == serial_add_pkg::T_SIGN
        && (cur.acc[37] ^ cur.opd[37]) |=> cur.sign_differs)
        else $error("sign difference missed");
    cmp_end_a: assert property (
        active && cur.step == 2'h1 && t0
        |=> cur.step == 2'h2 && cur.hold ##1 !$rose(cur.ws))
        else $error("compare step did not end");
    keep_results_a: assert property (
        (cur.step == 2'h2) ##1 (cur.step == 2'h2)
        |-> $stable(cur.sign_differs) && $stable(cur.mag_greater))
        else $error("comparison results disturbed");
    ovf_add_a: assert property (
        $rose(cur.overflow) |-> !$past(complement_enable))
        else $error("overflow set while complementing");
    ovf_halt_a: assert property (
        cur.overflow |=> cur.overflow || $past(write))
        else $error("overflow dropped without software");
    order_end_a: assert property (
        active && cur.step == 2'h2 && t0
        |=> cur.phase == serial_add_pkg::PH_ALPHA && cur.step == 2'h0
            && cur.hold)
        else $error("order did not end on t0");
    slot_step_a: assert property (
        cur.pulse == serial_add_pkg::T_SLOT_STEP && cur.slot != 4'h9
        |=> cur.slot == $past(cur.slot) + 4'h1)
        else $error("slot counter did not advance");
    pulse_wrap_a: assert property (
        cur.pulse == serial_add_pkg::T_LAST |=> cur.pulse == 6'h00 ##41
        cur.pulse == serial_add_pkg::T_LAST)
        else $error("minor cycle not 42 pulses");
    order_done_c: cover property (
        cur.step == 2'h2 ##1 cur.phase == serial_add_pkg::PH_ALPHA);
    complement_c: cover property (complement_enable && active);
    overflow_c: cover property ($rose(cur.overflow));
    word_select_c: cover property ($rose(cur.ws));
endmodule

// >>> serial_add_order_execution_test.sv
// self-checking bench for the serial add order
module serial_add_order_execution_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst_n = 0, read = 0, write = 0, mem_line;
    logic [4:0]  address = 5'h00;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic        waitrequest, word_select, strobe, settle_hold, overflow_flop;
    logic [20:0] function_line;
    logic [3:0]  word_slot_counter;
    logic [5:0]  pulse_source;
    logic [1:0]  step_counter, phase_counter;
    logic [41:0] mem_word = 42'h0, res;
    logic [42:0] exp;
    logic [3:0]  slot_req = 4'h0;
    logic        ws_prev = 1'b0;
    int          err_count = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    serial_add_order dut (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .memory_read_line(mem_line),
        .word_select(word_select), .readout_select_strobe(strobe),
        .function_line(function_line),
        .word_slot_counter(word_slot_counter), .pulse_source(pulse_source),
        .step_counter(step_counter), .phase_counter(phase_counter),
        .settle_hold(settle_hold), .overflow_flop(overflow_flop));
    mem_channel_model mem (.clk(clk), .word_select(word_select),
        .pulse_source(pulse_source), .stored_word(mem_word),
        .memory_read_line(mem_line));
    task automatic check(input string what, input logic [41:0] e,
                         input logic [41:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        // hold the request until waitrequest is seen low at an edge
        forever begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // sign-magnitude sum with overflow flag on top
    function automatic logic [42:0] add_ref(input logic [41:0] a, b);
        logic [30:0] s;
        logic        sg;
        sg = a[37];
        if (a[37] == b[37]) s = a[36:7] + b[36:7];
        else if (a[36:7] > b[36:7]) s = a[36:7] - b[36:7];
        else begin
            s = b[36:7] - a[36:7];
            sg = b[37];
        end
        if (s[29:0] == 30'h0) sg = 1'b0;
        return {s[30] & (a[37] == b[37]), 4'h0, sg, s[29:0], 7'h00};
    endfunction
    function automatic logic [41:0] rand_word();
        return {4'h0, 1'($urandom), 30'($urandom), 7'h00};
    endfunction
    task automatic run_order(input logic [41:0] a, b);
        exp = add_ref(a, b);
        mem_word <= b;
        bus(1, 5'h08, a[31:0]);
        bus(1, 5'h0C, {22'h0, a[41:32]});
        slot_req = 4'($urandom % 10);
        bus(1, 5'h00, {24'h0, slot_req, 4'h1});
        while (phase_counter !== 2'h2) @(negedge clk);
        while (phase_counter !== 2'h0) @(negedge clk);
        bus(0, 5'h10, 32'h0);
        res[31:0] = rd;
        bus(0, 5'h14, 32'h0);
        check("operand", b, {rd[9:0], res[31:0]});
        bus(0, 5'h08, 32'h0);
        res[31:0] = rd;
        bus(0, 5'h0C, 32'h0);
        check("sum", exp[41:0], {rd[9:0], res[31:0]});
        check("overflow", 42'(exp[42]), 42'(overflow_flop));
        check("end state", 42'h1, {step_counter, settle_hold});
    endtask
    // step lines and word select timing, sampled mid-cycle
    always @(negedge clk) begin
        if (phase_counter === 2'h2 && step_counter === 2'h1)
            check("step1 lines", 42'h3, 42'({function_line[13] &
                function_line[16], ~|{function_line[1], function_line[3],
                function_line[12], function_line[19]}}));
        if (word_select === 1'b1 && ws_prev !== 1'b1)
            check("select", 42'({1'b1, 6'h01, slot_req}),
                  42'({strobe, pulse_source, word_slot_counter}));
        if (word_select === 1'b0 && ws_prev === 1'b1)
            check("read end", 42'({2'h1, 1'b1, 6'h01}),
                  42'({step_counter, settle_hold, pulse_source}));
        ws_prev = word_select;
        if (phase_counter === 2'h2 && step_counter === 2'h2)
            check("step2 lines", 42'h1, 42'(function_line[10] &
                function_line[14] & function_line[20]));
    end
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(74553));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 5'h1C, 32'h0);
        check("unmapped", 42'h0, 42'(rd));
        // equal magnitudes, opposite signs: must give plus zero
        run_order({4'h0, 1'b1, 30'h00ABCDEF, 7'h0},
                  {4'h0, 1'b0, 30'h00ABCDEF, 7'h0});
        // same sign carry out of the top magnitude position
        run_order({4'h0, 1'b0, 30'h3FFFFFF0, 7'h0},
                  {4'h0, 1'b0, 30'h00000100, 7'h0});
        // smaller accumulator with differing signs takes the swap path
        run_order({4'h0, 1'b1, 30'h00000005, 7'h0},
                  {4'h0, 1'b0, 30'h20000000, 7'h0});
        repeat (8) run_order(rand_word(), rand_word());
        give_verdict();
    end
endmodule

// >>> serial_add_pkg.sv
// constants for the serial add order execution block
package serial_add_pkg;
    localparam int          WORD_W      = 42;
    localparam int          PULSE_W     = 6;
    localparam int          SLOT_W      = 4;
    localparam int          LINE_W      = 21;
    localparam logic [5:0]  PULSES      = 6'h2A;
    localparam logic [5:0]  T_FIRST     = 6'h00;
    localparam logic [5:0]  T_LAST      = 6'h29;
    localparam logic [5:0]  T_CLR_CMP   = 6'h01;
    localparam logic [5:0]  T_CLR_RES   = 6'h02;
    localparam logic [5:0]  T_SLOT_STEP = 6'h02;
    localparam logic [5:0]  T_MAG       = 6'h22;
    localparam logic [5:0]  T_SIGN      = 6'h23;
    localparam logic [5:0]  T_CP_FIRST  = 6'h06;
    localparam logic [5:0]  T_CP_LAST   = 6'h23;
    localparam logic [5:0]  CMP_OFS     = 6'h02;
    localparam logic [5:0]  ADD_OFS     = 6'h01;
    localparam logic [5:0]  P_MAG_LO    = 6'h07;
    localparam logic [5:0]  P_MAG_HI    = 6'h24;
    localparam logic [5:0]  P_SIGN      = 6'h25;
    localparam logic [3:0]  SLOT_LAST   = 4'h9;
    localparam int          LN_READ     = 1;
    localparam int          LN_STROBE   = 3;
    localparam int          LN_OPD_IN   = 12;
    localparam int          LN_READ_END = 19;
    localparam int          LN_CMP      = 13;
    localparam int          LN_CMP_AUX  = 16;
    localparam int          LN_ADD_END  = 10;
    localparam int          LN_HOLD_RES = 14;
    localparam int          LN_ADD      = 20;
    localparam logic [4:0]  REG_CTRL    = 5'h00;
    localparam logic [4:0]  REG_STATUS  = 5'h04;
    localparam logic [4:0]  REG_ACC_LO  = 5'h08;
    localparam logic [4:0]  REG_ACC_HI  = 5'h0C;
    localparam logic [4:0]  REG_OPD_LO  = 5'h10;
    localparam logic [4:0]  REG_OPD_HI  = 5'h14;
    localparam logic [4:0]  REG_LINES   = 5'h18;
    localparam int          CTRL_START  = 0;
    localparam int          CTRL_ABORT  = 1;
    localparam int          CTRL_SLOT_LO = 4;
    localparam int          HI_W        = 10;

    typedef enum logic [1:0] {
        PH_ALPHA,
        PH_BETA,
        PH_GAMMA,
        PH_DELTA
    } phase_t;
endpackage
